/* File: inc/pause_flow_control_consts.svh */
// How it works
// - Candidate: control multicast or station address.
// - Length/type must equal 0x8808.
// - Opcode must equal 0x0001.
// - Non-zero timer is XOFF, zero XON.
// - Timer counts slots of 64 byte times.
// - Received pause acted on only when enabled.
// - Auto-negotiation may rewrite pause enables.
// - XOFF loads timer, halts after current frame.
// - XOFF: report halted, forward frame.
// - Resume on timer expiry or XON.
// - XON: resume, report cleared, forward frame.
// - PCIe: controller request sends configured pause.
// - SMBus: fill above high sends XOFF.
// - SMBus: fill below low sends XON.
// - SMBus: refresh XOFF while fill stays high.
// - Type, time, refresh held as 16 bits.
// - Multicast sent/compared 01 first on wire.
// - Keep accepting transmit data into 3 KB.
// - In-band messages only between packets.
//
// Constants of the pause flow control block.
// Assumes a 200 MHz APB clock shared with the frame streams.
`ifndef PAUSE_FLOW_CONTROL_CONSTS_SVH
`define PAUSE_FLOW_CONTROL_CONSTS_SVH

`define REG_CTRL 8'h00
`define REG_TYPE 8'h04
`define REG_TIME 8'h08
`define REG_REFRESH 8'h0C
`define REG_THRESH 8'h10
`define REG_STA_LO 8'h14
`define REG_STA_HI 8'h18
`define REG_STATUS 8'h1C

`define CTRL_RX_EN 0
`define CTRL_TX_EN 1
`define CTRL_SMBUS 2

`define RST_CTRL 3'h0
`define RST_TYPE 16'h8808
`define RST_TIME 16'hFFFF
`define RST_REFRESH 16'h8000
`define RST_HIGH 16'h0A00
`define RST_LOW 16'h0400

`define CTRL_MCAST 48'h01_00_00_C2_80_01
`define PAUSE_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`define PAUSE_LAST_IDX 6'd59
`define RX_MIN_IDX 6'd18

`define TXBUF_DEPTH 3072
`define TXBUF_AW 12

`define SPEED_1G 2'b10
`define SPEED_100M 2'b01
`define CLK_MHZ 200
`define SLOT_NS_1G 512
`define SLOT_NS_100M 5120
`define SLOT_NS_10M 51200
`define SLOT_CYC_1G ((`SLOT_NS_1G * `CLK_MHZ) / 1000)
`define SLOT_CYC_100M ((`SLOT_NS_100M * `CLK_MHZ) / 1000)
`define SLOT_CYC_10M ((`SLOT_NS_10M * `CLK_MHZ) / 1000)

`endif

/* File: inc/pause_flow_control_pkg.sv */
// Types of the pause flow control block.
// Assumes the constants header is included by the design files.
package pause_flow_control_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_PAUSE, TX_DATA} tx_state_t;
   typedef logic [15:0] field16_t;
endpackage

/* File: logic/tx_buffer_mem.sv */
// Transmit buffer storage: one write port, one registered read port.
// Assumes the caller keeps addresses inside the buffer depth.
`timescale 1ns/10ps
`include "pause_flow_control_consts.svh"
module tx_buffer_mem (
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic [`TXBUF_AW-1:0] wr_addr,
   input wire logic [8:0] wr_data,
   input wire logic [`TXBUF_AW-1:0] rd_addr,
   output logic [8:0] rd_data
);
   logic [8:0] mem [0:`TXBUF_DEPTH-1];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read returns the old word when the same address is written at that edge.
   always_ff @(posedge pclk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

/* File: logic/pause_flow_control.sv */
// Pause flow control: receive pause detection, pause timer, transmit halt,
// in-band status reporting and local pause frame generation.
// Assumes all streams run on pclk; the wire MAC appends the FCS.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "pause_flow_control_consts.svh"
module pause_flow_control #(
   parameter int SLOT_CYC_10M = `SLOT_CYC_10M
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] link_speed,
   input wire logic an_update,
   input wire logic an_rx_pause,
   input wire logic an_tx_pause,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_out_valid,
   output logic [7:0] rx_out_data,
   output logic rx_out_last,
   output logic status_valid,
   output logic status_tx_off,
   input wire logic host_valid,
   input wire logic [7:0] host_data,
   input wire logic host_last,
   output logic host_ready,
   input wire logic ctl_req_valid,
   input wire logic ctl_req_xon,
   output logic ctl_req_ready,
   input wire logic [11:0] rx_fifo_level,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   output logic tx_halted
);
   logic [2:0] ctrl_q;
   pause_flow_control_pkg::field16_t type_q, time_q, refresh_q, high_q, low_q;
   logic [31:0] sta_lo_q;
   logic [15:0] sta_hi_q;
   logic [47:0] sta;
   logic [15:0] pause_timer_q;
   logic halted_d;
   logic xoff_sent_q;
   logic [15:0] refresh_cnt_q;
   logic [13:0] slot_cnt_q, slot_max;
   logic slot_tick;
   logic [5:0] rx_idx_q;
   logic rx_in_frame_q, mc_ok_q, sta_ok_q, type_ok_q, op_ok_q;
   logic [7:0] timer_hi_q;
   logic [15:0] timer_rx_q;
   logic pause_rx, rx_xoff, rx_xon;
   logic status_pend_q, status_val_q;
   logic host_in_frame_q;
   logic pause_req, pause_req_xon, pause_pend_q, pause_xon_q;
   logic [12:0] fill;
   pause_flow_control_pkg::tx_state_t state_q;
   logic [5:0] gen_idx_q;
   logic [15:0] gen_timer_q;
   logic [`TXBUF_AW-1:0] wr_ptr_q, rd_ptr_q, rd_ptr_d;
   logic [`TXBUF_AW-1:0] count_q, visible;
   logic push, pop, push_last_q, load, start_pause;
   logic [8:0] mem_q;
   logic wr_access;

   function automatic logic [7:0] byte_of(input logic [47:0] a, input logic [2:0] k);
      byte_of = a[{k, 3'b000} +: 8];
   endfunction

   function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [47:0] s,
                                             input logic [15:0] t, input logic [15:0] tm);
      if (i < 6'd6) begin
         frame_byte = byte_of(`CTRL_MCAST, i[2:0]);
      end else if (i < 6'd12) begin
         frame_byte = byte_of(s, 3'(i - 6'd6));
      end else begin
         case (i)
            6'd12: frame_byte = t[15:8];
            6'd13: frame_byte = t[7:0];
            6'd14: frame_byte = 8'(`PAUSE_OPCODE >> 8);
            6'd15: frame_byte = 8'(`PAUSE_OPCODE & 16'h00FF);
            6'd16: frame_byte = tm[15:8];
            6'd17: frame_byte = tm[7:0];
            default: frame_byte = 8'h00;
         endcase
      end
   endfunction

   assign sta = {sta_hi_q, sta_lo_q};
   assign pready = 1'b1;
   assign wr_access = psel && penable && pwrite;

   // Register writes; auto-negotiation results override the enables.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `RST_CTRL;
         type_q <= `RST_TYPE;
         time_q <= `RST_TIME;
         refresh_q <= `RST_REFRESH;
         high_q <= `RST_HIGH;
         low_q <= `RST_LOW;
         sta_lo_q <= 32'h0000_0000;
         sta_hi_q <= 16'h0000;
      end else begin
         if (wr_access) begin
            case (paddr)
               `REG_CTRL: ctrl_q <= pwdata[2:0];
               `REG_TYPE: type_q <= pwdata[15:0];
               `REG_TIME: time_q <= pwdata[15:0];
               `REG_REFRESH: refresh_q <= pwdata[15:0];
               `REG_THRESH: begin
                  low_q <= pwdata[15:0];
                  high_q <= pwdata[31:16];
               end
               `REG_STA_LO: sta_lo_q <= pwdata;
               `REG_STA_HI: sta_hi_q <= pwdata[15:0];
               default: ;
            endcase
         end
         if (an_update) begin
            ctrl_q[`CTRL_RX_EN] <= an_rx_pause;
            ctrl_q[`CTRL_TX_EN] <= an_tx_pause;
         end
      end
   end

   // Read data is captured in the setup phase and held through access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         case (paddr)
            `REG_CTRL: prdata <= {29'h0000_0000, ctrl_q};
            `REG_TYPE: prdata <= {16'h0000, type_q};
            `REG_TIME: prdata <= {16'h0000, time_q};
            `REG_REFRESH: prdata <= {16'h0000, refresh_q};
            `REG_THRESH: prdata <= {high_q, low_q};
            `REG_STA_LO: prdata <= sta_lo_q;
            `REG_STA_HI: prdata <= {16'h0000, sta_hi_q};
            `REG_STATUS: prdata <= {pause_timer_q, 14'h0000, xoff_sent_q, tx_halted};
            default: begin
               prdata <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   // Slot of 64 byte times per speed.
   always_comb begin
      case (link_speed)
         `SPEED_1G: slot_max = 14'(`SLOT_CYC_1G - 1);
         `SPEED_100M: slot_max = 14'(`SLOT_CYC_100M - 1);
         default: slot_max = 14'(SLOT_CYC_10M - 1);
      endcase
   end
   assign slot_tick = (slot_cnt_q >= slot_max);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_cnt_q <= 14'h0000;
      end else begin
         slot_cnt_q <= slot_tick ? 14'h0000 : slot_cnt_q + 14'h0001;
      end
   end

   // Receive parsing of destination, type, opcode and timer fields.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_idx_q <= 6'h00;
         rx_in_frame_q <= 1'b0;
         mc_ok_q <= 1'b0;
         sta_ok_q <= 1'b0;
         type_ok_q <= 1'b0;
         op_ok_q <= 1'b0;
         timer_hi_q <= 8'h00;
         timer_rx_q <= 16'h0000;
      end else if (rx_valid) begin
         rx_in_frame_q <= !rx_last;
         rx_idx_q <= rx_last ? 6'h00 : (rx_idx_q == 6'h3F ? rx_idx_q : rx_idx_q + 6'h01);
         if (rx_idx_q < 6'd6) begin
            mc_ok_q <= (rx_data == byte_of(`CTRL_MCAST, rx_idx_q[2:0])) &&
                       (rx_idx_q == 6'd0 || mc_ok_q);
            sta_ok_q <= (rx_data == byte_of(sta, rx_idx_q[2:0])) &&
                        (rx_idx_q == 6'd0 || sta_ok_q);
         end
         case (rx_idx_q)
            6'd12: timer_hi_q <= rx_data;
            6'd13: type_ok_q <= ({timer_hi_q, rx_data} == `PAUSE_TYPE);
            6'd14: timer_hi_q <= rx_data;
            6'd15: op_ok_q <= ({timer_hi_q, rx_data} == `PAUSE_OPCODE);
            6'd16: timer_hi_q <= rx_data;
            6'd17: timer_rx_q <= {timer_hi_q, rx_data};
            default: ;
         endcase
      end
   end

   assign pause_rx = rx_valid && rx_last && (rx_idx_q >= `RX_MIN_IDX) && (mc_ok_q || sta_ok_q) &&
                     type_ok_q && op_ok_q && ctrl_q[`CTRL_RX_EN];
   assign rx_xoff = pause_rx && (timer_rx_q != 16'h0000);
   assign rx_xon = pause_rx && (timer_rx_q == 16'h0000);

   // Pause timer and transmit halt state.
   always_comb begin
      halted_d = tx_halted;
      if (rx_xoff) begin
         halted_d = 1'b1;
      end else if (rx_xon) begin
         halted_d = 1'b0;
      end else if (tx_halted && slot_tick && pause_timer_q <= 16'h0001) begin
         halted_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_timer_q <= 16'h0000;
         tx_halted <= 1'b0;
      end else begin
         tx_halted <= halted_d;
         if (rx_xoff) begin
            pause_timer_q <= timer_rx_q;
         end else if (rx_xon) begin
            pause_timer_q <= 16'h0000;
         end else if (tx_halted && slot_tick && pause_timer_q != 16'h0000) begin
            pause_timer_q <= pause_timer_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_out_valid <= 1'b0;
         rx_out_data <= 8'h00;
         rx_out_last <= 1'b0;
      end else begin
         rx_out_valid <= rx_valid;
         rx_out_data <= rx_data;
         rx_out_last <= rx_valid && rx_last;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_pend_q <= 1'b0;
         status_val_q <= 1'b0;
         status_valid <= 1'b0;
         status_tx_off <= 1'b0;
      end else begin
         status_valid <= 1'b0;
         if (status_pend_q && !rx_in_frame_q && !rx_valid) begin
            status_valid <= 1'b1;
            status_tx_off <= status_val_q;
            status_pend_q <= 1'b0;
         end
         if (halted_d != tx_halted) begin
            status_pend_q <= 1'b1;
            status_val_q <= halted_d;
         end
      end
   end

   // Controller requests are taken only between host packets.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_in_frame_q <= 1'b0;
      end else if (host_valid && host_ready) begin
         host_in_frame_q <= !host_last;
      end
   end
   assign ctl_req_ready = !host_in_frame_q;

   // SMBus threshold state and pause request sources.
   assign fill = 13'(rx_fifo_level) + 13'(count_q);
   always_comb begin
      pause_req = 1'b0;
      pause_req_xon = 1'b0;
      if (ctrl_q[`CTRL_SMBUS]) begin
         if (ctrl_q[`CTRL_TX_EN]) begin
            if (!xoff_sent_q && 16'(fill) > high_q) begin
               pause_req = 1'b1;
            end else if (xoff_sent_q && 16'(fill) < low_q) begin
               pause_req = 1'b1;
               pause_req_xon = 1'b1;
            end else if (xoff_sent_q && slot_tick && refresh_cnt_q + 16'h0001 >= refresh_q) begin
               pause_req = 1'b1;
            end
         end
      // Controller asks for a pause frame.
      end else if (ctl_req_valid && ctl_req_ready) begin
         pause_req = 1'b1;
         pause_req_xon = ctl_req_xon;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xoff_sent_q <= 1'b0;
         refresh_cnt_q <= 16'h0000;
      end else if (!ctrl_q[`CTRL_SMBUS] || !ctrl_q[`CTRL_TX_EN]) begin
         xoff_sent_q <= 1'b0;
         refresh_cnt_q <= 16'h0000;
      end else if (pause_req) begin
         xoff_sent_q <= !pause_req_xon;
         refresh_cnt_q <= 16'h0000;
      end else if (xoff_sent_q && slot_tick) begin
         refresh_cnt_q <= refresh_cnt_q + 16'h0001;
      end
   end

   // A new request wins over the clear taken when a pause frame starts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_pend_q <= 1'b0;
         pause_xon_q <= 1'b0;
      end else if (pause_req) begin
         pause_pend_q <= 1'b1;
         pause_xon_q <= pause_req_xon;
      end else if (start_pause) begin
         pause_pend_q <= 1'b0;
      end
   end

   assign host_ready = (count_q != `TXBUF_AW'(`TXBUF_DEPTH));
   assign push = host_valid && host_ready;
   assign visible = count_q - `TXBUF_AW'(push_last_q);
   assign load = !tx_valid || tx_ready;
   assign pop = (state_q == pause_flow_control_pkg::TX_DATA) && load && (visible != '0);
   assign start_pause = (state_q == pause_flow_control_pkg::TX_IDLE) && load && pause_pend_q;
   assign rd_ptr_d = !pop ? rd_ptr_q :
                     (rd_ptr_q == `TXBUF_AW'(`TXBUF_DEPTH - 1) ? '0 : rd_ptr_q + 1'b1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         push_last_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == `TXBUF_AW'(`TXBUF_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_q + `TXBUF_AW'(push) - `TXBUF_AW'(pop);
         push_last_q <= push;
      end
   end

   tx_buffer_mem u_buf (
      .pclk(pclk),
      .wr_en(push),
      .wr_addr(wr_ptr_q),
      .wr_data({host_last, host_data}),
      .rd_addr(rd_ptr_d),
      .rd_data(mem_q)
   );

   // Transmit sequencer: pause frames first, buffered packets when not halted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pause_flow_control_pkg::TX_IDLE;
         gen_idx_q <= 6'h00;
         gen_timer_q <= 16'h0000;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
      end else if (load) begin
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         case (state_q)
            pause_flow_control_pkg::TX_IDLE: begin
               if (pause_pend_q) begin
                  state_q <= pause_flow_control_pkg::TX_PAUSE;
                  gen_idx_q <= 6'h00;
                  gen_timer_q <= pause_xon_q ? 16'h0000 : time_q;
               end else if (!tx_halted && visible != '0) begin
                  state_q <= pause_flow_control_pkg::TX_DATA;
               end
            end
            pause_flow_control_pkg::TX_PAUSE: begin
               tx_valid <= 1'b1;
               tx_data <= frame_byte(gen_idx_q, sta, type_q, gen_timer_q);
               tx_last <= (gen_idx_q == `PAUSE_LAST_IDX);
               gen_idx_q <= gen_idx_q + 6'h01;
               if (gen_idx_q == `PAUSE_LAST_IDX) begin
                  state_q <= pause_flow_control_pkg::TX_IDLE;
               end
            end
            pause_flow_control_pkg::TX_DATA: begin
               if (visible != '0) begin
                  tx_valid <= 1'b1;
                  tx_data <= mem_q[7:0];
                  tx_last <= mem_q[8];
                  if (mem_q[8]) begin
                     state_q <= pause_flow_control_pkg::TX_IDLE;
                  end
               end
            end
            default: state_q <= pause_flow_control_pkg::TX_IDLE;
         endcase
      end
   end
endmodule

/* File: verification/pause_flow_control_chk.sv */
// Concurrent checks on the ports of the pause flow control block.
// Assumes one clock, pclk, and the active-low reset presetn.
`timescale 1ns/10ps
module pause_flow_control_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_out_valid,
   input wire logic [7:0] rx_out_data,
   input wire logic rx_out_last,
   input wire logic status_valid,
   input wire logic status_tx_off,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready,
   input wire logic tx_halted
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_ready: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_status_pulse: assert property (status_valid |=> !status_valid) else $error("status longer than one cycle");
   a_halt_cause: assert property ($rose(tx_halted) |-> $past(rx_valid && rx_last))
      else $error("halt without a received frame end");
   a_halt_report: assert property ($rose(tx_halted) |-> ##[1:40] status_valid && status_tx_off)
      else $error("no halted status after halt");
   a_resume_report: assert property ($fell(tx_halted) |-> ##[1:40] status_valid && !status_tx_off)
      else $error("no cleared status after resume");
   a_rx_forward: assert property (rx_valid |=> rx_out_valid && rx_out_data == $past(rx_data)
      && rx_out_last == $past(rx_last)) else $error("receive byte not forwarded");
   a_rx_quiet: assert property (!rx_valid |=> !rx_out_valid) else $error("forwarded byte from nothing");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("transmit byte dropped while stalled");
   cover property ($rose(tx_halted));
   cover property ($fell(tx_halted));
   cover property (tx_valid && tx_ready && tx_last);
   cover property (psel && penable && pslverr);
endmodule

bind pause_flow_control pause_flow_control_chk chk_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_last(rx_last), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
   .rx_out_last(rx_out_last), .status_valid(status_valid), .status_tx_off(status_tx_off), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_halted(tx_halted));

/* File: verification/mac_sink.sv */
// Model of the wire MAC that takes the transmit stream and keeps every byte.
// Assumes the block drives tx_valid and tx_data from pclk.
`timescale 1ns/10ps
module mac_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] q[$];
   int seed = 11;
   // A real MAC may hold off bytes, so slow mode withdraws ready at random.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) tx_ready <= 1'b0;
      else tx_ready <= slow ? 1'($random(seed)) : 1'b1;
   end
   always @(posedge pclk) begin
      if (presetn && tx_valid && tx_ready) q.push_back(tx_data);
   end
endmodule

/* File: verification/pause_flow_control_tb_top.sv */
// Self-checking bench for the pause flow control block.
// Assumes the 10M slot is shortened to 20 cycles.
`timescale 1ns/10ps
module pause_flow_control_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, an_update = 0, an_rx_pause = 0, an_tx_pause = 0;
   logic rx_valid = 0, rx_last = 0, host_valid = 0, host_last = 0, ctl_req_valid = 0, ctl_req_xon = 0, slow = 0;
   logic [7:0] paddr = 0, rx_data = 0, host_data = 0, rx_out_data, tx_data;
   logic [31:0] pwdata = 0, rd, prdata;
   logic [1:0] link_speed = 0;
   logic [11:0] rx_fifo_level = 0;
   logic pready, pslverr, err, rx_out_valid, rx_out_last, status_valid, status_tx_off, host_ready, ctl_req_ready;
   logic tx_valid, tx_last, tx_ready, tx_halted;
   logic [47:0] sta;
   logic [15:0] tval;
   logic [7:0] e[$];
   logic [31:0] rv[6] = '{32'h0, 32'h8808, 32'hFFFF, 32'h8000, 32'h0A000400, 32'h0};
   localparam logic [47:0] MC = 48'h010000C28001;
   int seed = 32'h572f;
   int fails = 0, n_tests = 0, k;
   pause_flow_control #(.SLOT_CYC_10M(20)) pause_flow_control_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link_speed(link_speed), .an_update(an_update),
      .an_rx_pause(an_rx_pause), .an_tx_pause(an_tx_pause), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last),
      .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_last(rx_out_last),
      .status_valid(status_valid), .status_tx_off(status_tx_off), .host_valid(host_valid),
      .host_data(host_data), .host_last(host_last), .host_ready(host_ready), .ctl_req_valid(ctl_req_valid),
      .ctl_req_xon(ctl_req_xon), .ctl_req_ready(ctl_req_ready), .rx_fifo_level(rx_fifo_level),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_halted(tx_halted));
   mac_sink mac_sink_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task end_sim;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Builds a 60-byte pause frame image; rnd fills the pad with noise.
   task build(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] op, input logic [15:0] tm,
              input logic rnd);
      e = {};
      for (int i = 0; i < 6; i++) e.push_back(da[8*i+:8]);
      for (int i = 0; i < 6; i++) e.push_back(sta[8*i+:8]);
      e = {e, ty[15:8], ty[7:0], op[15:8], op[7:0], tm[15:8], tm[7:0]};
      while (e.size() < 60) e.push_back(rnd ? 8'($random(seed)) : 8'h00);
   endtask
   task rxf(input logic [47:0] da, input logic [15:0] ty, input logic [15:0] op, input logic [15:0] tm);
      build(da, ty, op, tm, 1'b1);
      foreach (e[i]) begin
         @(posedge pclk);
         rx_valid <= 1;
         rx_data <= e[i];
         rx_last <= (i == 59);
      end
      @(posedge pclk);
      rx_valid <= 0;
      rx_last <= 0;
      repeat (4) @(posedge pclk);
   endtask
   task cmpf(input int o, input logic [15:0] tm);
      build(MC, 16'h8808, 16'h0001, tm, 1'b0);
      chk(mac_sink_inst.q.size() >= o + 60, 1, "frame length");
      foreach (e[i]) chk(mac_sink_inst.q[o+i], e[i], "frame byte");
   endtask
   task waitq(input int n);
      for (k = 0; k < 3000 && mac_sink_inst.q.size() < n; k++) @(posedge pclk);
   endtask
   task req(input logic x);
      @(posedge pclk);
      ctl_req_valid <= 1;
      ctl_req_xon <= x;
      do @(posedge pclk); while (ctl_req_ready !== 1'b1);
      ctl_req_valid <= 0;
   endtask
   initial begin
      #200000;
      fails++;
      end_sim();
   end
   initial begin
      sta = {16'($random(seed)), 32'($random(seed))};
      tval = 16'($random(seed)) | 16'h0100;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 6; i++) begin
         apb(0, 8'(4 * i), 0);
         chk(rd, rv[i], "reset value");
      end
      apb(1, 8'h20, 32'($random(seed)));
      chk(err, 1, "unmapped write");
      apb(0, 8'h20, 0);
      chk(err, 1, "unmapped read");
      chk(rd, 0, "unmapped data");
      apb(1, 8'h08, {16'h0, tval});
      apb(1, 8'h14, sta[31:0]);
      apb(1, 8'h18, {16'h0, sta[47:32]});
      apb(0, 8'h08, 0);
      chk(rd, {16'h0, tval}, "pause time");
      apb(1, 8'h00, 32'h1);
      rxf(MC, 16'h8809, 16'h0001, 16'h5);
      chk(tx_halted, 0, "wrong type");
      rxf(MC, 16'h8808, 16'h0002, 16'h5);
      chk(tx_halted, 0, "wrong opcode");
      rxf(MC ^ 48'h1, 16'h8808, 16'h0001, 16'h5);
      chk(tx_halted, 0, "wrong address");
      apb(1, 8'h00, 32'h0);
      rxf(MC, 16'h8808, 16'h0001, 16'h5);
      chk(tx_halted, 0, "receive disabled");
      @(posedge pclk);
      an_rx_pause <= 1;
      an_tx_pause <= 1;
      an_update <= 1;
      @(posedge pclk);
      an_update <= 0;
      apb(0, 8'h00, 0);
      chk(rd[1:0], 2'b11, "negotiated enable");
      rxf(sta, 16'h8808, 16'h0001, 16'h3);
      chk({tx_halted, status_tx_off}, 2'b11, "station xoff");
      for (k = 0; k < 200 && tx_halted !== 1'b0; k++) @(posedge pclk);
      chk(k >= 30 && k <= 70, 1, "three slot expiry");
      repeat (5) @(posedge pclk);
      chk(status_tx_off, 0, "expiry status");
      link_speed <= 2'b10;
      rxf(sta, 16'h8808, 16'h0001, 16'h2);
      for (k = 0; k < 400 && tx_halted !== 1'b0; k++) @(posedge pclk);
      chk(k >= 90 && k <= 210, 1, "gigabit slot expiry");
      link_speed <= 2'b00;
      rxf(sta, 16'h8808, 16'h0001, 16'hFFFF);
      mac_sink_inst.q = {};
      @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         host_valid <= 1;
         host_data <= 8'(i);
         host_last <= (i == 7);
         do @(posedge pclk); while (host_ready !== 1'b1);
      end
      host_valid <= 0;
      host_last <= 0;
      repeat (50) @(posedge pclk);
      chk(mac_sink_inst.q.size(), 0, "held while paused");
      rxf(MC, 16'h8808, 16'h0001, 16'h0);
      chk({tx_halted, status_tx_off}, 2'b00, "xon resume");
      waitq(8);
      for (int i = 0; i < 8; i++) chk(mac_sink_inst.q[i], 8'(i), "buffered byte");
      apb(1, 8'h00, 32'h3);
      mac_sink_inst.q = {};
      slow <= 1;
      req(0);
      waitq(60);
      req(1);
      waitq(120);
      cmpf(0, tval);
      cmpf(60, 16'h0);
      slow <= 0;
      apb(1, 8'h0C, 32'hA);
      apb(1, 8'h00, 32'h7);
      mac_sink_inst.q = {};
      rx_fifo_level <= 12'hA01;
      waitq(120);
      rx_fifo_level <= 12'h0;
      waitq(180);
      cmpf(0, tval);
      cmpf(60, tval);
      cmpf(120, 16'h0);
      end_sim();
   end
endmodule
